//--- src/ces_map.svh
`ifndef CES_MAP_SVH
`define CES_MAP_SVH

// ----------------------------------------------------------------
// Status word layout
// ----------------------------------------------------------------
`define CES_SR_T        15
`define CES_SR_S        13
`define CES_SR_MASK     10:8
`define CES_SR_RESET    16'h2700
`define CES_LVL_NMI     3'h7

// ----------------------------------------------------------------
// Vector numbers and addressing
// ----------------------------------------------------------------
`define CES_VEC_ILLEGAL 8'h04
`define CES_VEC_DIVZERO 8'h05
`define CES_VEC_CHK     8'h06
`define CES_VEC_OVERFLOW_TRAP_OP   8'h07
`define CES_VEC_PRIV    8'h08
`define CES_VEC_ALINE   8'h0A
`define CES_VEC_FLINE   8'h0B
`define CES_VEC_SPUR    8'h18
`define CES_VEC_AUTO    8'h18
`define CES_VEC_TRAP    8'h20
`define CES_VEC_PAD     14'h0000
`define CES_VEC_LOW     2'h0
`define CES_RESET_ADDR  24'h00_0000
`define CES_WORD_STEP   24'h00_0002
`define CES_IACK_PAD    20'hF_FFFF
`define CES_IACK_A0     1'h1

// ----------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------
`define CES_LINE_A      4'hA
`define CES_LINE_F      4'hF
`define CES_OP_RSV0     16'h4AFA
`define CES_OP_RSV1     16'h4AFB
`define CES_OP_RSV2     16'h4AFC
`define CES_OP_ORI_SR   16'h007C
`define CES_OP_ANDI_SR  16'h027C
`define CES_OP_EORI_SR  16'h0A7C
`define CES_OP_TO_SR    16'h46C0
`define CES_OP_FROM_SR  16'h40C0
`define CES_MSK_EA      16'hFFC0
`define CES_OP_USP      16'h4E60
`define CES_MSK_USP     16'hFFF0
`define CES_OP_RESET    16'h4E70
`define CES_OP_STOP     16'h4E72
`define CES_OP_RTE      16'h4E73
`define CES_OP_CTRL     16'h4E7A
`define CES_MSK_CTRL    16'hFFFE
`define CES_OP_SPACE    16'h0E00
`define CES_MSK_SPACE   16'hFF00
`define CES_SPACE_SZ    7:6
`define CES_SZ_BAD      2'h3
`endif

//--- src/ces_pkg.sv
package ces_pkg;
	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_FETCH = 3'b001,
		ST_RUN   = 3'b010,
		ST_IACK  = 3'b011,
		ST_FRAME = 3'b100
	} ces_state_t;
endpackage

//--- src/ces_dec_if.sv
`timescale 1ns/1ps
// Decode request and verdict between the sequencer and the classifier
interface ces_dec_if;
	logic [15:0] opcode;
	logic        unmatched;
	logic        supervisor;
	logic        illegal;
	logic        aline;
	logic        fline;
	logic        priv;
	modport core (output opcode, output unmatched, output supervisor,
		input illegal, input aline, input fline, input priv);
	modport dec (input opcode, input unmatched, input supervisor,
		output illegal, output aline, output fline, output priv);
endinterface

//--- src/ces_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser; only the second stage is visible
module ces_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_q;

	// Clear both stages so no stale request survives reset
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta_q <= '0;
			q_out  <= '0;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule // ces_sync

//--- src/ces_decode.sv
`timescale 1ns/1ps
`include "ces_map.svh"
// Opcode classifier: unimplemented lines, privilege and illegal words
module ces_decode (
	ces_dec_if.dec d
);
	logic line_a, line_f, rsv, sr_imm, sr_move, priv_op;

	// Unimplemented lines win over every other class
	always_comb begin
		line_a  = d.opcode[15:12] == `CES_LINE_A;
		line_f  = d.opcode[15:12] == `CES_LINE_F;
		rsv     = d.opcode == `CES_OP_RSV0 || d.opcode == `CES_OP_RSV1
			|| d.opcode == `CES_OP_RSV2;
		sr_imm  = d.opcode == `CES_OP_ORI_SR || d.opcode == `CES_OP_ANDI_SR
			|| d.opcode == `CES_OP_EORI_SR;
		sr_move = (d.opcode & `CES_MSK_EA) == `CES_OP_TO_SR
			|| (d.opcode & `CES_MSK_EA) == `CES_OP_FROM_SR;
		// Address space move with size field 11 is not that opcode
		priv_op = sr_imm || sr_move
			|| (d.opcode & `CES_MSK_USP) == `CES_OP_USP
			|| d.opcode == `CES_OP_RESET || d.opcode == `CES_OP_STOP
			|| d.opcode == `CES_OP_RTE
			|| (d.opcode & `CES_MSK_CTRL) == `CES_OP_CTRL
			|| ((d.opcode & `CES_MSK_SPACE) == `CES_OP_SPACE
				&& d.opcode[`CES_SPACE_SZ] != `CES_SZ_BAD);
		d.aline   = line_a;
		d.fline   = line_f;
		d.illegal = !line_a && !line_f && (rsv || d.unmatched);
		d.priv    = !line_a && !line_f && !d.illegal && priv_op
			&& !d.supervisor;
	end
endmodule // ces_decode

//--- src/ces_exception_seq.sv
`timescale 1ns/1ps
`include "ces_map.svh"
// Exception sequencer: reset entry, interrupts, traps and decode faults
module ces_exception_seq #(
	parameter int RESET_PULSE_CYCLES = 16
) (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Interrupt request pins
	input  wire logic [2:0]  interrupt_level_inputs_in,
	// Bus pins for vector and acknowledge reads, and the external reset output
	input  wire logic        transfer_acknowledge_in,
	input  wire logic        bus_error_input_in,
	input  wire logic        autovector_in,
	input  wire logic [15:0] bus_rdata_in,
	output logic             bus_req_out,
	output logic             bus_iack_out,
	output logic [23:0]      bus_addr_out,
	output logic             ext_reset_out,
	// Decoder and execution unit
	input  wire logic        opcode_valid_in,
	input  wire logic [15:0] opcode_in,
	input  wire logic        opcode_unmatched_in,
	input  wire logic [23:0] current_pc_in,
	input  wire logic        instr_done_in,
	input  wire logic [23:0] next_pc_in,
	input  wire logic        trap_op_in,
	input  wire logic [3:0]  trap_num_in,
	input  wire logic        overflow_trap_op_in,
	input  wire logic        overflow_in,
	input  wire logic        bounds_check_op_in,
	input  wire logic        bounds_fail_in,
	input  wire logic        signed_divide_op_in,
	input  wire logic        unsigned_divide_op_in,
	input  wire logic        divisor_zero_in,
	input  wire logic        reset_op_in,
	input  wire logic        sr_write_in,
	input  wire logic [15:0] sr_wdata_in,
	output logic             busy_out,
	output logic [15:0]      status_word_out,
	output logic             ssp_load_out,
	output logic             pc_load_out,
	output logic [31:0]      load_value_out,
	output logic             frame_valid_out,
	output logic             frame_short_out,
	output logic [15:0]      frame_sr_out,
	output logic [23:0]      frame_pc_out,
	output logic [7:0]       frame_vector_out
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0]  ipl_s;
	logic        ack_s, bus_error_input_s, avec_s;
	logic [15:0] rdata_s;

	ces_sync #(.W(3)) u_ipl_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.d_in     (interrupt_level_inputs_in),
		.q_out    (ipl_s)
	);

	// Data is held stable by the responder while the strobe stands
	ces_sync #(.W(19)) u_bus_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.d_in     ({transfer_acknowledge_in, bus_error_input_in, autovector_in,
			bus_rdata_in}),
		.q_out    ({ack_s, bus_error_input_s, avec_s, rdata_s})
	);

	// ----------------------------------------------------------------
	// Opcode classifier
	// ----------------------------------------------------------------
	ces_dec_if dif ();
	logic [15:0] sr_q, sr_d;

	assign dif.opcode     = opcode_in;
	assign dif.unmatched  = opcode_unmatched_in;
	assign dif.supervisor = sr_q[`CES_SR_S];

	ces_decode u_decode (
		.d (dif.dec)
	);

	// ----------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------
	ces_pkg::ces_state_t state_q, state_d;
	// Local names for the package's state codes, nothing is imported
	localparam ces_pkg::ces_state_t ST_RESET = ces_pkg::ST_RESET;
	localparam ces_pkg::ces_state_t ST_FETCH = ces_pkg::ST_FETCH;
	localparam ces_pkg::ces_state_t ST_RUN   = ces_pkg::ST_RUN;
	localparam ces_pkg::ces_state_t ST_IACK  = ces_pkg::ST_IACK;
	localparam ces_pkg::ces_state_t ST_FRAME = ces_pkg::ST_FRAME;
	logic [1:0]  idx_q, idx_d;
	logic [23:0] addr_q, addr_d, pc_save_q, pc_save_d;
	logic [15:0] sr_copy_q, sr_copy_d, hi_q, hi_d;
	logic [7:0]  vec_q, vec_d, trap_vec;
	logic [2:0]  lvl_q, lvl_d, ipl_prev_q, int_lvl;
	logic        kind_rst_q, kind_rst_d, short_q, short_d, nmi_q, nmi_d;
	logic        frame_q, frame_d, ssp_ld_q, ssp_ld_d, pc_ld_q, pc_ld_d;
	logic [31:0] value_q, value_d;
	logic        resp_prev_q, resp_edge, nmi_edge, trap_hit, dec_hit, int_take;

	// Response edge keeps a lingering strobe from ending the next read
	assign resp_edge = (ack_s || bus_error_input_s || avec_s) && !resp_prev_q;
	assign nmi_edge  = ipl_s == `CES_LVL_NMI && ipl_prev_q != `CES_LVL_NMI;
	assign dec_hit   = dif.illegal || dif.aline || dif.fline || dif.priv;
	// Held level seven passes once the mask drops below it
	assign int_take  = nmi_q || ipl_s > sr_q[`CES_SR_MASK];
	assign int_lvl   = nmi_q ? `CES_LVL_NMI : ipl_s;

	// Trap conditions reported by the execution unit at completion
	always_comb begin
		trap_hit = trap_op_in || (overflow_trap_op_in && overflow_in)
			|| (bounds_check_op_in && bounds_fail_in)
			|| ((signed_divide_op_in || unsigned_divide_op_in)
				&& divisor_zero_in);
		if (trap_op_in) begin
			trap_vec = `CES_VEC_TRAP + {4'h0, trap_num_in};
		end else if (overflow_trap_op_in && overflow_in) begin
			trap_vec = `CES_VEC_OVERFLOW_TRAP_OP;
		end else if (bounds_check_op_in && bounds_fail_in) begin
			trap_vec = `CES_VEC_CHK;
		end else begin
			trap_vec = `CES_VEC_DIVZERO;
		end
	end

	// Next-state logic for the sequencer
	always_comb begin
		state_d    = state_q;
		idx_d      = idx_q;
		addr_d     = addr_q;
		sr_d       = sr_q;
		sr_copy_d  = sr_copy_q;
		pc_save_d  = pc_save_q;
		hi_d       = hi_q;
		vec_d      = vec_q;
		lvl_d      = lvl_q;
		kind_rst_d = kind_rst_q;
		short_d    = short_q;
		value_d    = value_q;
		nmi_d      = nmi_q;
		frame_d    = 1'b0;
		ssp_ld_d   = 1'b0;
		pc_ld_d    = 1'b0;
		case (state_q)
			ST_RESET: begin
				state_d    = ST_FETCH;
				idx_d      = '0;
				addr_d     = `CES_RESET_ADDR;
				kind_rst_d = 1'b1;
			end
			ST_FETCH: begin
				if (resp_edge) begin
					hi_d   = rdata_s;
					addr_d = addr_q + `CES_WORD_STEP;
					idx_d  = idx_q + 2'h1;
					if (idx_q[0]) begin
						value_d = {hi_q, rdata_s};
						if (kind_rst_q && !idx_q[1]) begin
							ssp_ld_d = 1'b1;
						end else begin
							pc_ld_d = 1'b1;
							state_d = ST_RUN;
						end
					end
				end
			end
			ST_IACK: begin
				if (resp_edge) begin
					state_d = ST_FRAME;
					if (bus_error_input_s) begin
						vec_d   = `CES_VEC_SPUR;
						short_d = 1'b1;
					end else if (avec_s) begin
						vec_d = `CES_VEC_AUTO + {5'h00, lvl_q};
					end else begin
						vec_d = rdata_s[7:0];
					end
				end
			end
			ST_FRAME: begin
				frame_d    = 1'b1;
				state_d    = ST_FETCH;
				idx_d      = '0;
				kind_rst_d = 1'b0;
				addr_d     = {`CES_VEC_PAD, vec_q, `CES_VEC_LOW};
			end
			ST_RUN: begin
				if (sr_write_in) begin
					sr_d = sr_wdata_in;
				end
				if (opcode_valid_in && dec_hit) begin
					// Decode faults stack the faulting word's own address
					state_d   = ST_FRAME;
					pc_save_d = current_pc_in;
					short_d   = 1'b0;
					if (dif.aline) begin
						vec_d = `CES_VEC_ALINE;
					end else if (dif.fline) begin
						vec_d = `CES_VEC_FLINE;
					end else if (dif.illegal) begin
						vec_d = `CES_VEC_ILLEGAL;
					end else begin
						vec_d = `CES_VEC_PRIV;
					end
				end else if (instr_done_in && trap_hit) begin
					state_d   = ST_FRAME;
					pc_save_d = next_pc_in;
					vec_d     = trap_vec;
					short_d   = 1'b0;
				end else if (instr_done_in && int_take) begin
					// Only sampled at an instruction boundary
					state_d   = ST_IACK;
					lvl_d     = int_lvl;
					pc_save_d = next_pc_in;
					short_d   = 1'b0;
					addr_d    = {`CES_IACK_PAD, int_lvl, `CES_IACK_A0};
					sr_d[`CES_SR_MASK] = int_lvl;
					if (int_lvl == `CES_LVL_NMI) begin
						nmi_d = 1'b0;
					end
				end
				if (state_d != ST_RUN) begin
					sr_copy_d = sr_q;
					sr_d[`CES_SR_S] = 1'b1;
					sr_d[`CES_SR_T] = 1'b0;
				end
			end
			default: begin
				state_d = ST_RESET;
			end
		endcase
		// A new edge beats the clear made by its acceptance
		if (nmi_edge) begin
			nmi_d = 1'b1;
		end
	end

	// Sequencer registers
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q     <= ST_RESET;
			sr_q        <= `CES_SR_RESET;
			idx_q       <= '0;
			addr_q      <= '0;
			sr_copy_q   <= '0;
			pc_save_q   <= '0;
			hi_q        <= '0;
			vec_q       <= '0;
			lvl_q       <= '0;
			kind_rst_q  <= 1'b1;
			short_q     <= 1'b0;
			value_q     <= '0;
			nmi_q       <= 1'b0;
			frame_q     <= 1'b0;
			ssp_ld_q    <= 1'b0;
			pc_ld_q     <= 1'b0;
			ipl_prev_q  <= '0;
			resp_prev_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			sr_q        <= sr_d;
			idx_q       <= idx_d;
			addr_q      <= addr_d;
			sr_copy_q   <= sr_copy_d;
			pc_save_q   <= pc_save_d;
			hi_q        <= hi_d;
			vec_q       <= vec_d;
			lvl_q       <= lvl_d;
			kind_rst_q  <= kind_rst_d;
			short_q     <= short_d;
			value_q     <= value_d;
			nmi_q       <= nmi_d;
			frame_q     <= frame_d;
			ssp_ld_q    <= ssp_ld_d;
			pc_ld_q     <= pc_ld_d;
			ipl_prev_q  <= ipl_s;
			resp_prev_q <= ack_s || bus_error_input_s || avec_s;
		end
	end

	// ----------------------------------------------------------------
	// External reset pulse
	// ----------------------------------------------------------------
	logic [7:0] rcnt_q, rcnt_d;
	logic       ext_rst_q, ext_rst_d;

	// Pulse length counted here; the core keeps running meanwhile
	always_comb begin
		rcnt_d = rcnt_q;
		if (state_q == ST_RUN && reset_op_in && sr_q[`CES_SR_S]) begin
			rcnt_d = 8'(RESET_PULSE_CYCLES);
		end else if (rcnt_q != '0) begin
			rcnt_d = rcnt_q - 8'h01;
		end
		ext_rst_d = rcnt_d != '0;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rcnt_q    <= '0;
			ext_rst_q <= 1'b0;
		end else begin
			rcnt_q    <= rcnt_d;
			ext_rst_q <= ext_rst_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus_req_out      = state_q == ST_FETCH || state_q == ST_IACK;
	assign bus_iack_out     = state_q == ST_IACK;
	assign busy_out         = state_q != ST_RUN;
	assign bus_addr_out     = addr_q;
	assign ext_reset_out    = ext_rst_q;
	assign status_word_out  = sr_q;
	assign ssp_load_out     = ssp_ld_q;
	assign pc_load_out      = pc_ld_q;
	assign load_value_out   = value_q;
	assign frame_valid_out  = frame_q;
	assign frame_short_out  = short_q;
	assign frame_sr_out     = sr_copy_q;
	assign frame_pc_out     = pc_save_q;
	assign frame_vector_out = vec_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_reset_status: assert property ($rose(rst_n_in) |-> sr_q == `CES_SR_RESET
		&& state_q == ST_RESET) else $error("reset status wrong");
	a_reset_noframe: assert property (kind_rst_q |-> !frame_valid_out)
		else $error("frame pushed during reset entry");
	a_ext_reset_len: assert property ($rose(ext_reset_out) |-> ext_reset_out[*8])
		else $error("external reset pulse too short");
	a_nmi_edge: assert property (nmi_edge && state_q == ST_RUN && !instr_done_in
		|=> nmi_q) else $error("level seven edge lost");
	a_defer_pending: assert property (state_q == ST_RUN && instr_done_in
		&& !trap_hit && !nmi_q && ipl_s <= sr_q[`CES_SR_MASK]
		&& !(opcode_valid_in && dec_hit) |=> state_q == ST_RUN)
		else $error("masked request taken");
	a_iack_entry: assert property (state_q == ST_RUN && $past(state_q) != ST_RUN
		##0 1'b1 or (state_q == ST_RUN ##1 state_q == ST_IACK) |->
		bus_addr_out[3:1] == lvl_q && sr_q[`CES_SR_S] && !sr_q[`CES_SR_T]
		&& sr_q[`CES_SR_MASK] == lvl_q || state_q != ST_IACK)
		else $error("acknowledge entry wrong");
	a_autovector: assert property (state_q == ST_IACK && resp_edge && !bus_error_input_s
		&& avec_s |=> vec_q == `CES_VEC_AUTO + {5'h00, lvl_q} && state_q == ST_FRAME)
		else $error("autovector number wrong");
	a_spurious: assert property (state_q == ST_IACK && resp_edge && bus_error_input_s
		|=> vec_q == `CES_VEC_SPUR && short_q ##1 frame_valid_out)
		else $error("spurious path wrong");
	a_vector_addr: assert property (frame_valid_out |->
		bus_addr_out == {`CES_VEC_PAD, vec_q, `CES_VEC_LOW} && state_q == ST_FETCH)
		else $error("vector address wrong");
	a_illegal_pc: assert property (state_q == ST_RUN && opcode_valid_in
		&& dif.illegal |=> vec_q == `CES_VEC_ILLEGAL
		&& pc_save_q == $past(current_pc_in) ##1 frame_valid_out && frame_sr_out[`CES_SR_S]
		== $past(sr_q[`CES_SR_S], 2)) else $error("illegal frame wrong");
	a_trap_vector: assert property (state_q == ST_RUN && !(opcode_valid_in && dec_hit)
		&& instr_done_in && trap_op_in |=> vec_q == `CES_VEC_TRAP + {4'h0,
		$past(trap_num_in)} && pc_save_q == $past(next_pc_in))
		else $error("trap vector wrong");
endmodule // ces_exception_seq

//--- test/ces_peer_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Memory and interrupting peripherals on the far side of the bus
// -----------------------------------------------------------------
module ces_peer_model (
	input  wire logic        clk_in,
	input  wire logic        req_in,
	input  wire logic        iack_in,
	input  wire logic [23:0] addr_in,
	input  wire logic [1:0]  mode_in,
	input  wire logic [7:0]  vec_in,
	input  wire logic [3:0]  dly_in,
	output logic             ack_out,
	output logic             bus_error_input_out,
	output logic             avec_out,
	output logic [15:0]      rdata_out
);
	logic [15:0] last;
	// Strobe held three cycles, then dropped so the next edge is clean
	initial begin
		ack_out = 1'b0;
		bus_error_input_out = 1'b0;
		avec_out = 1'b0;
		last = 16'h0000;
		rdata_out = 16'hFFFF;
		forever begin
			@(posedge clk_in);
			if (req_in) begin
				repeat (dly_in) @(posedge clk_in);
				last = iack_in ? {8'h00, vec_in} : {8'h5A, addr_in[7:0]};
				rdata_out <= last;
				if (!iack_in || mode_in == 2'h0) ack_out <= 1'b1;
				else if (mode_in == 2'h1) avec_out <= 1'b1;
				else bus_error_input_out <= 1'b1;
				repeat (3) @(posedge clk_in);
				{ack_out, bus_error_input_out, avec_out} <= 3'b000;
				rdata_out <= ~last; // Released data must not look valid
				repeat (2) @(posedge clk_in);
			end
		end
	end
endmodule // ces_peer_model

//--- test/ces_exception_seq_test.sv
`timescale 1ns/1ps
module ces_exception_seq_test;
	localparam int PULSE = 16;
	logic clk_in = 0, rst_n_in = 0, bus_req_out, bus_iack_out, ext_reset_out, busy_out;
	logic transfer_acknowledge_in, bus_error_input_in, autovector_in, opcode_valid_in;
	logic opcode_unmatched_in = 0, instr_done_in = 0, trap_op_in = 0, overflow_trap_op_in = 0;
	logic overflow_in = 0, bounds_check_op_in = 0, bounds_fail_in = 0, signed_divide_op_in = 0;
	logic unsigned_divide_op_in = 0, divisor_zero_in = 0, reset_op_in = 0, sr_write_in = 0;
	logic ssp_load_out, pc_load_out, frame_valid_out, frame_short_out;
	logic [2:0]  interrupt_level_inputs_in = 3'h0;
	logic [1:0]  mode = 2'h0;
	logic [3:0]  trap_num_in = 4'h0, dly = 4'h1;
	logic [7:0]  pvec = 8'h00, frame_vector_out;
	logic [15:0] bus_rdata_in, opcode_in = 16'h0000, sr_wdata_in = 16'h0000;
	logic [15:0] status_word_out, frame_sr_out;
	logic [23:0] current_pc_in = 24'h00_2000, next_pc_in = 24'h00_2004;
	logic [23:0] bus_addr_out, frame_pc_out;
	logic [31:0] load_value_out;
	int n_errors = 0;
	int check_count = 0;

	always #2.5 clk_in = ~clk_in;

	ces_exception_seq #(.RESET_PULSE_CYCLES(PULSE)) ces_exception_seq_inst (.clk_in, .rst_n_in,
		.interrupt_level_inputs_in, .transfer_acknowledge_in, .bus_error_input_in,
		.autovector_in, .bus_rdata_in, .bus_req_out, .bus_iack_out, .bus_addr_out,
		.ext_reset_out, .opcode_valid_in, .opcode_in, .opcode_unmatched_in, .current_pc_in,
		.instr_done_in, .next_pc_in, .trap_op_in, .trap_num_in, .overflow_trap_op_in,
		.overflow_in, .bounds_check_op_in, .bounds_fail_in, .signed_divide_op_in,
		.unsigned_divide_op_in, .divisor_zero_in, .reset_op_in, .sr_write_in, .sr_wdata_in,
		.busy_out, .status_word_out, .ssp_load_out, .pc_load_out, .load_value_out,
		.frame_valid_out, .frame_short_out, .frame_sr_out, .frame_pc_out, .frame_vector_out);

	ces_peer_model ces_peer_model_inst (.clk_in, .req_in(bus_req_out), .iack_in(bus_iack_out),
		.addr_in(bus_addr_out), .mode_in(mode), .vec_in(pvec), .dly_in(dly),
		.ack_out(transfer_acknowledge_in), .bus_error_input_out(bus_error_input_in),
		.avec_out(autovector_in), .rdata_out(bus_rdata_in));

	// -----------------------------------------------------------------
	// Checking and closing
	// -----------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Two words the peer returns for a long read at a
	function automatic logic [31:0] vword(input logic [23:0] a);
		return {8'h5A, a[7:0], 8'h5A, 8'(a[7:0] + 8'h02)};
	endfunction

	// Bounded wait: 0 frame, 1 pc load, 2 idle, 3 stack load
	task automatic wait_sig(input int k);
		for (int i = 0; i < 200; i++) begin
			@(posedge clk_in);
			#1;
			if ((k == 0 && frame_valid_out === 1'b1) || (k == 1 && pc_load_out === 1'b1)
				|| (k == 2 && busy_out === 1'b0) || (k == 3 && ssp_load_out === 1'b1)) return;
		end
		chk(32'h0, 32'h1);
		print_verdict();
	endtask

	// -----------------------------------------------------------------
	// Core-side drivers
	// -----------------------------------------------------------------
	task automatic decode(input logic [15:0] op, input logic um);
		@(posedge clk_in);
		opcode_valid_in <= 1'b1;
		opcode_in <= op;
		opcode_unmatched_in <= um;
		@(posedge clk_in);
		opcode_valid_in <= 1'b0;
	endtask

	// f: 0 plain, 1 trap, 2 overflow, 3 bounds, 4 signed div, 5 unsigned div
	task automatic finish_op(input int f, input logic [3:0] n);
		@(posedge clk_in);
		instr_done_in <= 1'b1;
		trap_op_in <= f == 1;
		trap_num_in <= n;
		{overflow_trap_op_in, overflow_in} <= {2{f == 2}};
		{bounds_check_op_in, bounds_fail_in} <= {2{f == 3}};
		signed_divide_op_in <= f == 4;
		unsigned_divide_op_in <= f == 5;
		divisor_zero_in <= f >= 4;
		@(posedge clk_in);
		{instr_done_in, trap_op_in, overflow_trap_op_in, overflow_in} <= 4'h0;
		{bounds_check_op_in, bounds_fail_in, signed_divide_op_in} <= 3'h0;
		{unsigned_divide_op_in, divisor_zero_in} <= 2'h0;
	endtask

	task automatic set_sr(input logic [15:0] v);
		@(posedge clk_in);
		sr_write_in <= 1'b1;
		sr_wdata_in <= v;
		@(posedge clk_in);
		sr_write_in <= 1'b0;
		#1;
		chk(status_word_out, v);
	endtask

	// Frame contents, then handler entry through the vector
	task automatic expect_frame(input logic [7:0] v, input logic [23:0] pc, input logic sh,
		input logic [15:0] sr);
		wait_sig(0);
		chk(frame_vector_out, v);
		chk(frame_pc_out, pc);
		chk(frame_short_out, sh);
		chk(frame_sr_out, sr);
		chk(status_word_out[15:13], 3'h1);
		wait_sig(1);
		chk(load_value_out, vword({14'h0000, v, 2'h0}));
		wait_sig(2);
	endtask

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic irq(input logic [2:0] lv, input logic [1:0] m, input logic [7:0] dv,
		input logic [7:0] ev, input logic [15:0] sr);
		@(posedge clk_in);
		interrupt_level_inputs_in <= lv;
		mode <= m;
		pvec <= dv;
		repeat (4) @(posedge clk_in);
		finish_op(0, 4'h0);
		@(posedge clk_in);
		#1;
		chk({bus_iack_out, bus_addr_out}, {1'b1, 20'hF_FFFF, lv, 1'b1});
		expect_frame(ev, next_pc_in, m == 2'h2, sr);
		chk(status_word_out[10:8], lv);
	endtask

	task automatic decode_faults();
		logic [15:0] ops [6] = '{16'hA123, 16'hF456, 16'h4AFA, 16'h4AFB, 16'h4AFC, 16'h1234};
		logic [7:0]  vs [6] = '{8'h0A, 8'h0B, 8'h04, 8'h04, 8'h04, 8'h04};
		for (int i = 0; i < 6; i++) begin
			decode(ops[i], i == 5);
			expect_frame(vs[i], current_pc_in, 1'b0, 16'h2000);
		end
	endtask

	task automatic traps();
		int fs [6] = '{1, 1, 2, 3, 4, 5};
		logic [3:0] ns [6] = '{4'h0, 4'hF, 4'h0, 4'h0, 4'h0, 4'h0};
		logic [7:0] tv [6] = '{8'h20, 8'h2F, 8'h07, 8'h06, 8'h05, 8'h05};
		for (int i = 0; i < 6; i++) begin
			finish_op(fs[i], ns[i]);
			expect_frame(tv[i], next_pc_in, 1'b0, 16'h2000);
		end
	endtask

	task automatic reset_op();
		int n;
		n = 0;
		@(posedge clk_in);
		reset_op_in <= 1'b1;
		@(posedge clk_in);
		reset_op_in <= 1'b0;
		// First sample falls in the cycle the pulse starts
		for (int i = 0; i < 40; i++) begin
			#1;
			if (ext_reset_out === 1'b1) n++;
			@(posedge clk_in);
		end
		#1;
		chk(n, PULSE);
		chk(busy_out, 1'b0);
	endtask

	task automatic masked();
		int seen;
		seen = 0;
		set_sr(16'h2500);
		@(posedge clk_in);
		interrupt_level_inputs_in <= 3'h5;
		repeat (4) @(posedge clk_in);
		finish_op(0, 4'h0);
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_in);
			#1;
			if (busy_out !== 1'b0) seen++;
		end
		chk(seen, 0);
	endtask

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		opcode_valid_in = 1'b0;
		repeat (20) @(posedge clk_in);
		#1;
		chk(status_word_out, 16'h2700);
		@(posedge clk_in);
		rst_n_in <= 1'b1;
		wait_sig(3);
		chk(load_value_out, vword(24'h00_0000));
		wait_sig(1);
		chk(load_value_out, vword(24'h00_0004));
		wait_sig(2);
		set_sr(16'h2000);
		decode_faults();
		dly <= 4'h6;
		traps();
		reset_op();
		masked();
		irq(3'h6, 2'h1, 8'h00, 8'h1E, 16'h2500);
		set_sr(16'h2000);
		irq(3'h2, 2'h2, 8'h00, 8'h18, 16'h2000);
		dly <= 4'h1;
		irq(3'h4, 2'h0, 8'h0F, 8'h0F, 16'h2200);
		set_sr(16'h2700);
		irq(3'h7, 2'h1, 8'h00, 8'h1F, 16'h2700);
		set_sr(16'h2000);
		finish_op(0, 4'h0);
		expect_frame(8'h1F, next_pc_in, 1'b0, 16'h2000);
		@(posedge clk_in);
		interrupt_level_inputs_in <= 3'h0;
		set_sr(16'h0000);
		decode(16'h4E73, 1'b0);
		expect_frame(8'h08, current_pc_in, 1'b0, 16'h0000);
		print_verdict();
	end
endmodule // ces_exception_seq_test
